// >>> hdl/pei_top.sv
/*
 Power event input logic: power button debounce and override, wake edge
 detection, reset button pulse, thermal trip shutdown and resume holdoff.
 Assumes one always-on 100 MHz clock; every pin is asynchronous and is
 synchronised here.
*/
`timescale 1ns/1ps

// Behaviour
// - Select zero adds sixteen ms debounce
// - Four second press forces S5 in S0 to S4 only
// - Override waits on no other subsystem
// - Level flag after or before debounce
// - Wake request falling edge raises event
// - Internal wake bit raises same event
// - Debounced reset button starts host reset
// - Reset pulse held five to six ms
// - Rearm after release, S0, platform reset
// - Power cycle bit selects full reset
// - Reset button only with core power
// - Thermal trip drops sleep outputs, flag
// - Trip glitches under 25 ns ignored
// - Valid point picks trip monitoring start
// - Processor power loss stops trip monitoring
// - Thermal trip clears button press flag
// - Holdoff delays resume only in Sx
// - No flash access during sleep-A/holdoff
// - Holdoff pin is input until enabled
module pei_top
#(
	parameter int DEBOUNCE_LONG  = pei_pkg::DEBOUNCE_LONG_CYC,
	parameter int DEBOUNCE_SHORT = pei_pkg::DEBOUNCE_SHORT_CYC,
	parameter int OVERRIDE       = pei_pkg::OVERRIDE_CYC,
	parameter int RESET_PULSE    = pei_pkg::RESET_PULSE_CYC
)
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Platform pins
	input  wire logic power_button_n,
	input  wire logic wake_request_n,
	input  wire logic reset_button_n,
	input  wire logic thermal_trip_n,
	input  wire logic core_power_good,
	input  wire logic processor_power_good,
	input  wire logic platform_reset_n,
	input  wire logic resume_holdoff_n,
	// State from the sleep sequencer
	input  wire logic in_full_s0,
	input  wire logic in_s0_to_s4,
	input  wire logic sleep_a_n,
	input  wire logic resume_request,
	input  wire logic flash_request,
	// Configuration
	input  wire logic button_debounce_select,
	input  wire logic power_cycle_select,
	input  wire logic trip_valid_select,
	input  wire logic holdoff_enable,
	input  wire logic internal_wake_request,
	input  wire logic button_press_clear,
	input  wire logic thermal_flag_clear,
	// Events and status
	output logic      button_level_flag,
	output logic      button_press_flag,
	output logic      thermal_power_fail_flag,
	output logic      wake_event,
	output logic      override_shutdown,
	output logic      host_reset_warm,
	output logic      host_reset_cycle,
	output logic      sleep_s3_n,
	output logic      sleep_s4_n,
	output logic      sleep_s5_n,
	output logic      resume_go,
	output logic      flash_grant,
	output logic      holdoff_gpio_level
);
	// ------------------------------------------------------------
	// Synchronisers for the level inputs
	// ------------------------------------------------------------
	logic [5:0] lv1_r;
	logic [5:0] lv2_r;
	logic       cpg;
	logic       ppg;
	logic       prst_n;
	logic       hold_n;
	logic       wake_s;
	logic       trip_s;

	// Both stages registered; only lv2_r feeds logic
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			lv1_r <= 6'h3F;
			lv2_r <= 6'h3F;
		end
		else
		begin
			lv1_r <= {core_power_good, processor_power_good,
				platform_reset_n, resume_holdoff_n, wake_request_n,
				thermal_trip_n};
			lv2_r <= lv1_r;
		end
	end

	assign cpg    = lv2_r[5];
	assign ppg    = lv2_r[4];
	assign prst_n = lv2_r[3];
	assign hold_n = lv2_r[2];
	assign wake_s = lv2_r[1];
	assign trip_s = lv2_r[0];

	// ------------------------------------------------------------
	// Button and reset button debounce
	// ------------------------------------------------------------
	logic pb_sync_n;
	logic pb_clean_n;
	logic rb_clean_n;

	// Short hold only when select is one; zero gives 16 ms
	pei_filter #(.HOLD(DEBOUNCE_LONG)) u_pb
	(
		.clk        (clk),
		.rst        (rst),
		.pin_n      (power_button_n),
		.hold_short (button_debounce_select),
		.short_hold (DEBOUNCE_SHORT),
		.sync_n     (pb_sync_n),
		.clean_n    (pb_clean_n)
	);

	pei_filter #(.HOLD(DEBOUNCE_LONG)) u_rb
	(
		.clk        (clk),
		.rst        (rst),
		.pin_n      (reset_button_n),
		.hold_short (1'h0),
		.short_hold (DEBOUNCE_LONG),
		.sync_n     (),
		.clean_n    (rb_clean_n)
	);

	// ------------------------------------------------------------
	// Thermal trip glitch filter and valid window
	// ------------------------------------------------------------
	logic [7:0] tg_r;
	logic [7:0] tg_nxt;
	logic       trip_ok_r;
	logic       trip_ok_nxt;
	logic       prst_d_r;
	logic       ppg_d_r;
	logic       trip_hit;

	// Low must last past the glitch width before it counts
	always_comb
	begin
		tg_nxt = trip_s ? 8'h0 : tg_r;
		if (!trip_s && tg_r < 8'(pei_pkg::TRIP_GLITCH_CYC))
			tg_nxt = tg_r + 8'h1;
		trip_ok_nxt = trip_ok_r;
		if (!trip_valid_select && prst_n && !prst_d_r)
			trip_ok_nxt = 1'h1;
		if (trip_valid_select && ppg && !ppg_d_r)
			trip_ok_nxt = 1'h1;
		if (!ppg)
			trip_ok_nxt = 1'h0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tg_r      <= 8'h0;
			trip_ok_r <= 1'h0;
			// Idle levels of the synchronisers: no false edge after reset
			prst_d_r  <= 1'h1;
			ppg_d_r   <= 1'h1;
		end
		else
		begin
			tg_r      <= tg_nxt;
			trip_ok_r <= trip_ok_nxt;
			prst_d_r  <= prst_n;
			ppg_d_r   <= ppg;
		end
	end

	assign trip_hit = trip_ok_r &&
		(tg_r >= 8'(pei_pkg::TRIP_GLITCH_CYC));

	// ------------------------------------------------------------
	// Button override timer, flags and wake edge
	// ------------------------------------------------------------
	logic [31:0] ov_r;
	logic [31:0] ov_nxt;
	logic        ovs_r;
	logic        ovs_nxt;
	logic        pbd_r;
	logic        lvl_r;
	logic        lvl_nxt;
	logic        press_r;
	logic        press_nxt;
	logic        wk_d_r;
	logic        iw_d_r;
	logic        wake_r;
	logic        wake_nxt;

	always_comb
	begin
		// No handshake gates the override, nor core power good
		ov_nxt  = 32'h0;
		ovs_nxt = 1'h0;
		if (!pb_clean_n && in_s0_to_s4)
		begin
			ov_nxt = ov_r;
			if (ov_r < 32'(OVERRIDE))
				ov_nxt = ov_r + 32'h1;
			else
				ovs_nxt = 1'h1;
		end
		lvl_nxt = button_debounce_select ? !pb_sync_n
			: !pb_clean_n;
		press_nxt = press_r;
		if (button_press_clear)
			press_nxt = 1'h0;
		if (!pb_clean_n && pbd_r)
			press_nxt = 1'h1;
		if (trip_hit)
			press_nxt = 1'h0;
		wake_nxt = (!wake_s && wk_d_r)
			|| (internal_wake_request && !iw_d_r);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ov_r    <= 32'h0;
			ovs_r   <= 1'h0;
			pbd_r   <= 1'h1;
			lvl_r   <= 1'h0;
			press_r <= 1'h0;
			wk_d_r  <= 1'h1;
			iw_d_r  <= 1'h0;
			wake_r  <= 1'h0;
		end
		else
		begin
			ov_r    <= ov_nxt;
			ovs_r   <= ovs_nxt;
			pbd_r   <= pb_clean_n;
			lvl_r   <= lvl_nxt;
			press_r <= press_nxt;
			wk_d_r  <= wake_s;
			iw_d_r  <= internal_wake_request;
			wake_r  <= wake_nxt;
		end
	end

	// ------------------------------------------------------------
	// Reset button sequencer
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		RB_IDLE  = 2'b00,
		RB_PULSE = 2'b01,
		RB_WAIT  = 2'b10
	} pei_rb_t;

	pei_rb_t     rb_r;
	pei_rb_t     rb_nxt;
	logic [31:0] rc_r;
	logic [31:0] rc_nxt;
	logic        cyc_r;
	logic        cyc_nxt;
	logic        warm_o_r;
	logic        cyc_o_r;

	always_comb
	begin
		rb_nxt  = rb_r;
		rc_nxt  = 32'h0;
		cyc_nxt = cyc_r;
		case (rb_r)
			RB_IDLE:
				if (!rb_clean_n && cpg)
				begin
					rb_nxt  = RB_PULSE;
					cyc_nxt = power_cycle_select;
				end
			RB_PULSE:
			begin
				// Input level ignored during the pulse
				rc_nxt = rc_r + 32'h1;
				if (rc_r + 32'h1 >= 32'(RESET_PULSE))
					rb_nxt = RB_WAIT;
			end
			RB_WAIT:
				if (rb_clean_n && in_full_s0 && prst_n)
					rb_nxt = RB_IDLE;
			default:
				rb_nxt = RB_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rb_r     <= RB_IDLE;
			rc_r     <= 32'h0;
			cyc_r    <= 1'h0;
			warm_o_r <= 1'h0;
			cyc_o_r  <= 1'h0;
		end
		else
		begin
			rb_r     <= rb_nxt;
			rc_r     <= rc_nxt;
			cyc_r    <= cyc_nxt;
			warm_o_r <= (rb_nxt == RB_PULSE) && !cyc_nxt;
			cyc_o_r  <= (rb_nxt == RB_PULSE) && cyc_nxt;
		end
	end

	// ------------------------------------------------------------
	// Thermal shutdown and resume holdoff
	// ------------------------------------------------------------
	logic tpf_r;
	logic tpf_nxt;
	logic slp_r;
	logic slp_nxt;
	logic go_r;
	logic go_nxt;
	logic fl_r;
	logic fl_nxt;
	logic hg_r;
	logic hold_act;
	logic sx_r;
	logic sx_nxt;

	// Holdoff counts only when firmware has enabled the function
	assign hold_act = holdoff_enable && !hold_n;

	always_comb
	begin
		// Set wins over a same-cycle clear
		tpf_nxt = (tpf_r && !thermal_flag_clear) || trip_hit;
		// Sleep outputs low from one cycle after a hit; stay low
		slp_nxt = slp_r && !trip_hit && !ovs_r;
		// Entry window opens with sleep-A, closes once holdoff lets go
		sx_nxt = !sleep_a_n || (sx_r && hold_act);
		go_nxt = resume_request && !(sx_r && hold_act);
		fl_nxt = flash_request && sleep_a_n && !hold_act;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tpf_r <= 1'h0;
			slp_r <= pei_pkg::SLEEP_RST;
			go_r  <= 1'h0;
			fl_r  <= 1'h0;
			hg_r  <= 1'h1;
			sx_r  <= 1'h0;
		end
		else
		begin
			sx_r  <= sx_nxt;
			tpf_r <= tpf_nxt;
			slp_r <= slp_nxt;
			go_r  <= go_nxt;
			fl_r  <= fl_nxt;
			hg_r  <= hold_n;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all from flip-flops
	// ------------------------------------------------------------
	assign button_level_flag       = lvl_r;
	assign button_press_flag       = press_r;
	assign thermal_power_fail_flag = tpf_r;
	assign wake_event              = wake_r;
	assign override_shutdown       = ovs_r;
	assign host_reset_warm         = warm_o_r;
	assign host_reset_cycle        = cyc_o_r;
	assign sleep_s3_n              = slp_r;
	assign sleep_s4_n              = slp_r;
	assign sleep_s5_n              = slp_r;
	assign resume_go               = go_r;
	assign flash_grant             = fl_r;
	assign holdoff_gpio_level      = hg_r;
endmodule

// >>> hdl/pei_pkg.sv
/*
 Constants for the power event input logic: timing figures and counts.
 Assumes a 100 MHz always-on clock.
*/
package pei_pkg;
	// ------------------------------------------------------------
	// Clock
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int CLK_NS  = 10;

	// ------------------------------------------------------------
	// Times in their own units
	// ------------------------------------------------------------
	localparam int DEBOUNCE_LONG_MS  = 16;
	localparam int DEBOUNCE_SHORT_US = 500;
	localparam int OVERRIDE_S        = 4;
	localparam int RESET_PULSE_MS    = 5;
	localparam int TRIP_GLITCH_NS    = 25;

	// ------------------------------------------------------------
	// Derived cycle counts (least times rounded up)
	// ------------------------------------------------------------
	localparam int DEBOUNCE_LONG_CYC  = DEBOUNCE_LONG_MS * 1000 * CLK_MHZ;
	localparam int DEBOUNCE_SHORT_CYC = DEBOUNCE_SHORT_US * CLK_MHZ;
	localparam int OVERRIDE_CYC       = OVERRIDE_S * 1000 * 1000 * CLK_MHZ;
	// Five ms plus a margin: the pulse lands inside the 5 to 6 ms window
	localparam int RESET_PULSE_CYC    = RESET_PULSE_MS * 1000 * CLK_MHZ
		+ 50000;
	localparam int TRIP_GLITCH_CYC    =
		(TRIP_GLITCH_NS + CLK_NS - 1) / CLK_NS;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic SLEEP_RST = 1'h1;
endpackage

// >>> hdl/pei_filter.sv
/*
 Synchronise and debounce one active-low input; the output changes only
 after the synchronised input has held a new level for HOLD cycles, or
 for short_hold cycles when hold_short is set.
 Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module pei_filter
#(
	parameter int HOLD = 4
)
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Pin and result
	input  wire logic pin_n,
	input  wire logic hold_short,
	input  wire logic [31:0] short_hold,
	output logic      sync_n,
	output logic      clean_n
);
	logic        s1_r;
	logic        s2_r;
	logic        s2_nxt;
	logic        clean_r;
	logic        clean_nxt;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic [31:0] limit;

	// ------------------------------------------------------------
	// Debounce counter
	// ------------------------------------------------------------
	always_comb
	begin
		limit     = hold_short ? short_hold : 32'(HOLD);
		s2_nxt    = s1_r;
		clean_nxt = clean_r;
		cnt_nxt   = 32'h0;
		if (s2_r != clean_r)
		begin
			cnt_nxt = cnt_r + 32'h1;
			if (cnt_r + 32'h1 >= limit)
			begin
				clean_nxt = s2_r;
				cnt_nxt   = 32'h0;
			end
		end
	end

	// Only the second stage is read by logic
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s1_r    <= 1'h1;
			s2_r    <= 1'h1;
			clean_r <= 1'h1;
			cnt_r   <= 32'h0;
		end
		else
		begin
			s1_r    <= pin_n;
			s2_r    <= s2_nxt;
			clean_r <= clean_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	assign sync_n  = s2_r;
	assign clean_n = clean_r;
endmodule

// >>> verif/pei_top_props.sv
/*
 Concurrent checks on the ports of pei_top.
 Assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module pei_top_props
#(
	parameter int OVERRIDE    = 50,
	parameter int RESET_PULSE = 30
)
(
	// Clock, reset and inputs
	input wire logic clk, rst, power_button_n, wake_request_n,
	input wire logic core_power_good, processor_power_good,
	input wire logic sleep_a_n, resume_holdoff_n, holdoff_enable,
	// Outputs watched
	input wire logic button_press_flag, thermal_power_fail_flag,
	input wire logic wake_event, override_shutdown, resume_go,
	input wire logic host_reset_warm, host_reset_cycle, flash_grant,
	input wire logic sleep_s3_n, sleep_s4_n, sleep_s5_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	int  pc_r;
	int  pc_nxt;
	int  lc_r;
	int  lc_nxt;
	wire pulse = host_reset_warm | host_reset_cycle;
	// Reset pulse length and raw press length, both in cycles
	always_comb
	begin
		pc_nxt = (rst || !pulse) ? 0 : pc_r + 1;
		lc_nxt = (rst || power_button_n) ? 0 : lc_r + 1;
	end
	always_ff @(posedge clk)
	begin
		pc_r <= pc_nxt;
		lc_r <= lc_nxt;
	end
	sequence s_trip; $rose(thermal_power_fail_flag); endsequence
	sequence s_ovr; $rose(override_shutdown); endsequence
	property p_sleep_same; sleep_s3_n == sleep_s4_n && sleep_s4_n == sleep_s5_n;
	endproperty
	property p_trip_drop; s_trip |-> ##[0:3] !sleep_s3_n; endproperty
	property p_trip_press; s_trip |-> ##[0:1] !button_press_flag; endproperty
	property p_trip_window;
		!processor_power_good [*8] |-> !$rose(thermal_power_fail_flag);
	endproperty
	property p_wake_edge; $fell(wake_request_n) |-> ##[2:6] wake_event;
	endproperty
	property p_wake_pulse; wake_event |=> !wake_event; endproperty
	property p_ovr_time; s_ovr |-> lc_r >= OVERRIDE; endproperty
	property p_ovr_drop; s_ovr |-> ##[0:3] !sleep_s5_n; endproperty
	property p_pulse_len; $fell(pulse) |-> pc_r == RESET_PULSE; endproperty
	property p_one_kind; !(host_reset_warm && host_reset_cycle); endproperty
	property p_core_pg; !core_power_good [*8] |-> !$rose(pulse); endproperty
	property p_flash; !sleep_a_n [*2] |-> !flash_grant; endproperty
	property p_holdoff;
		(holdoff_enable && !resume_holdoff_n) [*4] |-> !$rose(resume_go);
	endproperty
	a_sleep_same: assert property (p_sleep_same)
		else $error("sleep outputs differ");
	a_trip_drop: assert property (p_trip_drop)
		else $error("trip left sleep high");
	a_trip_press: assert property (p_trip_press)
		else $error("trip kept press flag");
	a_trip_window: assert property (p_trip_window)
		else $error("trip honoured without power good");
	a_wake_edge: assert property (p_wake_edge)
		else $error("no wake event on fall");
	a_wake_pulse: assert property (p_wake_pulse)
		else $error("wake event too long");
	a_ovr_time: assert property (p_ovr_time)
		else $error("override too early");
	a_ovr_drop: assert property (p_ovr_drop)
		else $error("override left sleep high");
	a_pulse_len: assert property (p_pulse_len)
		else $error("reset pulse length wrong");
	a_one_kind: assert property (p_one_kind)
		else $error("both reset kinds at once");
	a_core_pg: assert property (p_core_pg)
		else $error("reset without core power");
	a_flash: assert property (p_flash)
		else $error("flash granted in sleep-A");
	a_holdoff: assert property (p_holdoff)
		else $error("resume during holdoff");
endmodule

// >>> verif/pei_ec_model.sv
/*
 Embedded controller model driving the resume holdoff pin.
 Assumes sleep-A and the flash grant come from the same clock.
*/
`timescale 1ns/1ps
module pei_ec_model
#(
	parameter int WATCH = 8,
	parameter int BUSY  = 12
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic sleep_a_n,
	input  wire logic flash_grant,
	output logic      resume_holdoff_n
);
	int   cnt;
	logic sa_q;
	// Hold off from sleep-A entry, watch, then use flash and let go
	always @(posedge clk)
	begin
		sa_q <= sleep_a_n;
		if (rst)
		begin
			cnt <= 0;
			resume_holdoff_n <= 1'h1;
		end
		else if (sa_q && !sleep_a_n)
		begin
			cnt <= 1;
			resume_holdoff_n <= 1'h0;
		end
		else if (cnt > 0)
		begin
			// Flash seen in the window: give up until S0 again
			if ((cnt <= WATCH && flash_grant) || cnt == WATCH + BUSY)
			begin
				cnt <= 0;
				resume_holdoff_n <= 1'h1;
			end
			else
				cnt <= cnt + 1;
		end
	end
endmodule

// >>> verif/pei_top_test.sv
/*
 Directed testbench for pei_top with shortened timing parameters.
 Assumes the controller model on the holdoff pin.
*/
`timescale 1ns/1ps
module pei_top_test;
	localparam int DL = 20;
	localparam int DS = 5;
	localparam int OV = 50;
	localparam int RP = 30;
	logic clk = 1'h0, rst = 1'h1;
	// Pins and sequencer levels
	logic power_button_n = 1'h1, wake_request_n = 1'h1;
	logic reset_button_n = 1'h1, thermal_trip_n = 1'h1;
	logic platform_reset_n = 1'h1, sleep_a_n = 1'h1;
	logic core_power_good = 1'h1, processor_power_good = 1'h1;
	logic in_full_s0 = 1'h1, in_s0_to_s4 = 1'h0;
	logic resume_request = 1'h0, flash_request = 1'h0;
	// Settings
	logic button_debounce_select = 1'h0, power_cycle_select = 1'h0;
	logic trip_valid_select = 1'h1, holdoff_enable = 1'h0;
	logic internal_wake_request = 1'h0, button_press_clear = 1'h0;
	logic thermal_flag_clear = 1'h0;
	// Outputs
	logic resume_holdoff_n, button_level_flag, button_press_flag;
	logic thermal_power_fail_flag, wake_event, override_shutdown;
	logic host_reset_warm, host_reset_cycle, sleep_s3_n, sleep_s4_n;
	logic sleep_s5_n, resume_go, flash_grant, holdoff_gpio_level;
	int   miscompares = 0;
	int   samples_checked = 0;
	pei_top #(.DEBOUNCE_LONG(DL), .DEBOUNCE_SHORT(DS), .OVERRIDE(OV),
		.RESET_PULSE(RP)) u_dut (.*);
	pei_ec_model u_ec (.clk, .rst, .sleep_a_n, .flash_grant,
		.resume_holdoff_n);
	initial forever #5 clk = ~clk;
	// ----------
	// Helpers
	// ----------
	task automatic final_report;
		$display("Checked %0d, mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic cyc(input int n); repeat (n) @(negedge clk); endtask
	task automatic do_reset; rst = 1'h1; cyc(20); rst = 1'h0; cyc(3);
	endtask
	// Bounded wait; running out ends the run
	task automatic wait_for(ref logic s, input logic v, input int lim,
		input string n);
		int i;
		for (i = 0; i < lim && s !== v; i++) cyc(1);
		chk(n, v, s);
		if (s !== v) final_report;
	endtask
	task automatic stay_lo(ref logic s, input int n, input string nm);
		logic seen;
		seen = 1'h0;
		repeat (n) begin cyc(1); seen |= s; end
		chk(nm, 1'h0, seen);
	endtask
	// ----------
	// Scenarios
	// ----------
	task automatic t_button;
		power_button_n = 1'h0; cyc(DL - 5);
		chk("level early", 1'h0, button_level_flag);
		wait_for(button_level_flag, 1'h1, 20, "level");
		power_button_n = 1'h1; cyc(DL + 10);
		button_debounce_select = 1'h1; power_button_n = 1'h0; cyc(4);
		chk("raw level", 1'h1, button_level_flag);
		power_button_n = 1'h1; cyc(DS + 10); button_debounce_select = 1'h0;
	endtask
	task automatic t_override;
		in_s0_to_s4 = 1'h1; core_power_good = 1'h0;
		power_button_n = 1'h0; cyc(OV - 10); power_button_n = 1'h1;
		cyc(DL + 5); power_button_n = 1'h0; cyc(DL + OV - 10);
		chk("override early", 1'h0, override_shutdown);
		wait_for(override_shutdown, 1'h1, 30, "override");
		cyc(4); chk("override sleep", 1'h0, sleep_s5_n);
		power_button_n = 1'h1; in_s0_to_s4 = 1'h0; core_power_good = 1'h1;
		do_reset;
	endtask
	task automatic t_wake;
		wake_request_n = 1'h0;
		wait_for(wake_event, 1'h1, 10, "wake fall");
		cyc(5); wake_request_n = 1'h1;
		stay_lo(wake_event, 10, "wake rise");
		internal_wake_request = 1'h1;
		wait_for(wake_event, 1'h1, 10, "wake bit");
		internal_wake_request = 1'h0;
	endtask
	task automatic t_rst_btn;
		core_power_good = 1'h0; reset_button_n = 1'h0;
		stay_lo(host_reset_warm, DL + 10, "no core power");
		reset_button_n = 1'h1; cyc(DL + 5); core_power_good = 1'h1; cyc(10);
		reset_button_n = 1'h0;
		wait_for(host_reset_warm, 1'h1, DL + 10, "warm reset");
		chk("not cycle", 1'h0, host_reset_cycle);
		reset_button_n = 1'h1; cyc(RP - 5);
		chk("pulse held", 1'h1, host_reset_warm);
		wait_for(host_reset_warm, 1'h0, 10, "pulse end");
		in_full_s0 = 1'h0; cyc(DL + 5); reset_button_n = 1'h0;
		stay_lo(host_reset_warm, DL + RP, "no rearm");
		reset_button_n = 1'h1; cyc(DL + 5); in_full_s0 = 1'h1;
		power_cycle_select = 1'h1; cyc(3); reset_button_n = 1'h0;
		wait_for(host_reset_cycle, 1'h1, DL + 10, "cycle reset");
		reset_button_n = 1'h1; cyc(RP + 5); power_cycle_select = 1'h0;
	endtask
	task automatic t_trip;
		power_button_n = 1'h0; cyc(DL + 5); power_button_n = 1'h1;
		chk("press set", 1'h1, button_press_flag);
		processor_power_good = 1'h0; thermal_trip_n = 1'h0;
		stay_lo(thermal_power_fail_flag, 12, "trip unpowered");
		thermal_trip_n = 1'h1; processor_power_good = 1'h1; cyc(5);
		thermal_trip_n = 1'h0; cyc(2); thermal_trip_n = 1'h1;
		stay_lo(thermal_power_fail_flag, 10, "trip glitch");
		thermal_trip_n = 1'h0;
		wait_for(thermal_power_fail_flag, 1'h1, 20, "trip flag");
		chk("trip s3", 1'h0, sleep_s3_n);
		chk("trip s4", 1'h0, sleep_s4_n);
		chk("trip press", 1'h0, button_press_flag);
		thermal_trip_n = 1'h1; do_reset; trip_valid_select = 1'h0;
		platform_reset_n = 1'h0; thermal_trip_n = 1'h0;
		stay_lo(thermal_power_fail_flag, 12, "trip in reset");
		platform_reset_n = 1'h1;
		wait_for(thermal_power_fail_flag, 1'h1, 20, "trip valid");
		thermal_trip_n = 1'h1; cyc(4); thermal_flag_clear = 1'h1; cyc(1);
		thermal_flag_clear = 1'h0; cyc(2);
		chk("flag clear", 1'h0, thermal_power_fail_flag);
		do_reset;
	endtask
	task automatic t_holdoff;
		sleep_a_n = 1'h0; cyc(6);
		chk("gpio level", 1'h0, holdoff_gpio_level);
		sleep_a_n = 1'h1; cyc(25); holdoff_enable = 1'h1;
		flash_request = 1'h1; sleep_a_n = 1'h0;
		stay_lo(flash_grant, 5, "flash in sleep");
		sleep_a_n = 1'h1; resume_request = 1'h1;
		stay_lo(resume_go, 10, "resume held");
		chk("flash held", 1'h0, flash_grant);
		wait_for(resume_go, 1'h1, 30, "resume");
		wait_for(flash_grant, 1'h1, 5, "flash");
	endtask
	initial
	begin
		do_reset;
		chk("reset s5", 1'h1, sleep_s5_n);
		chk("reset flag", 1'h0, thermal_power_fail_flag);
		t_button;
		t_override;
		t_wake;
		t_rst_btn;
		t_trip;
		t_holdoff;
		final_report;
	end
endmodule
bind pei_top pei_top_props #(.OVERRIDE(OVERRIDE),
	.RESET_PULSE(RESET_PULSE)) u_props (.*);
